// *** rtl/error_queue.sv ***
// Error code queue held in flip-flops
`timescale 1ns/10ps
`default_nettype none
module error_queue
  import status_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_push,
  input wire logic [ERR_W-1:0] i_push_code,
  input wire logic i_pop,
  input wire logic i_clear,
  output logic [ERR_W-1:0] o_head,
  output logic o_empty
);
  logic [ERR_W-1:0] mem [ERRQ_DEPTH];
  logic [ERRQ_PTR_W-1:0] rd_ptr;
  logic [ERRQ_PTR_W-1:0] wr_ptr;
  logic [ERRQ_CNT_W-1:0] count;
  logic [ERRQ_PTR_W-1:0] next_rd_ptr;
  logic [ERRQ_PTR_W-1:0] next_wr_ptr;
  logic [ERRQ_CNT_W-1:0] next_count;
  logic do_push;

  // Clear first, then one pop and one push; a full queue drops the newcomer
  always_comb
  begin
    next_rd_ptr = i_clear ? '0 : rd_ptr;
    next_wr_ptr = i_clear ? '0 : wr_ptr;
    next_count = i_clear ? '0 : count;
    if (i_pop && !i_clear && count != '0)
    begin
      next_rd_ptr = rd_ptr + 1'b1;
      next_count = next_count - 1'b1;
    end
    do_push = i_push && (next_count != ERRQ_CNT_W'(ERRQ_DEPTH));
    if (do_push)
    begin
      next_wr_ptr = next_wr_ptr + 1'b1;
      next_count = next_count + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  // Storage write, no reset needed for data
  always_ff @(posedge i_clock)
  begin
    if (do_push)
    begin
      mem[i_clear ? '0 : wr_ptr] <= i_push_code;
    end
  end

  assign o_head = mem[rd_ptr];
  assign o_empty = (count == '0);

  // One entry per error while room remains
  err_push_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_push && !i_pop && !i_clear && count < ERRQ_CNT_W'(ERRQ_DEPTH))
    |=> count == $past(count) + 1'b1) else $error("error push did not add one entry");
  err_pop_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_pop && !i_push && !i_clear && count != '0) |=> count == $past(count) - 1'b1)
    else $error("error read did not remove one entry");
endmodule
`default_nettype wire

// *** rtl/status_event_reg.sv ***
// Condition and event part of one 16-bit status register
`timescale 1ns/10ps
`default_nettype none
module status_event_reg
  import status_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [15:0] i_cond,
  input wire logic [15:0] i_used_mask,
  input wire logic i_read_clear,
  input wire logic i_clear,
  output logic [15:0] o_cond,
  output logic [15:0] o_event
);
  logic [15:0] cond;
  logic [15:0] event_bits;
  logic [15:0] next_cond;
  logic [15:0] next_event;

  // Condition follows the masked input one cycle later; event latches rising edges, set beats clear
  always_comb
  begin
    next_cond = i_cond & i_used_mask;
    next_event = event_bits;
    if (i_read_clear || i_clear)
    begin
      next_event = WORD_RESET;
    end
    next_event = next_event | (next_cond & ~cond);
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cond <= WORD_RESET;
      event_bits <= WORD_RESET;
    end
    else
    begin
      cond <= next_cond;
      event_bits <= next_event;
    end
  end

  assign o_cond = cond;
  assign o_event = event_bits;

  // Event bit latches on a rising condition
  event_latch_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (next_cond != WORD_RESET && cond == WORD_RESET) |=> (event_bits & cond) == cond)
    else $error("event part missed a rising condition");
endmodule
`default_nettype wire

// *** rtl/status_pkg.sv ***
// Shared constants and command codes for the status reporting block
package status_pkg;
  localparam int SREG_W = 16;
  localparam int BYTE_W = 8;
  localparam int ERR_W = 16;
  localparam int ERRQ_DEPTH = 8;
  localparam int ERRQ_PTR_W = 3;
  localparam int ERRQ_CNT_W = 4;
  // Operation register bit positions and used-bit masks
  localparam int OPR_CAL_BIT = 0;
  localparam int OPR_SWEEP_BIT = 3;
  localparam logic [15:0] OPR_USED_MASK = 16'h0009;
  localparam logic [15:0] QUES_USED_MASK = 16'h0000;
  // Status byte layout
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam logic [7:0] SRQ_SOURCE_MASK = 8'h34;
  localparam logic [7:0] SRE_WRITE_MASK = 8'hbf;
  localparam int ESR_OPC_BIT = 0;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

  // Command codes presented by the command parser
  typedef enum logic [4:0] {
    CMD_CLS = 5'h00,
    CMD_ESE_W = 5'h01,
    CMD_ESE_R = 5'h02,
    CMD_ESR_R = 5'h03,
    CMD_SRE_W = 5'h04,
    CMD_SRE_R = 5'h05,
    CMD_STB_R = 5'h06,
    CMD_PRE_W = 5'h07,
    CMD_PRE_R = 5'h08,
    CMD_PSC_W = 5'h09,
    CMD_PSC_R = 5'h0a,
    CMD_RST = 5'h0b,
    CMD_SYS_PRESET = 5'h0c,
    CMD_STAT_PRESET = 5'h0d,
    CMD_OPER_COND_R = 5'h0e,
    CMD_OPER_EVEN_R = 5'h0f,
    CMD_OPER_ENAB_W = 5'h10,
    CMD_QUES_COND_R = 5'h11,
    CMD_QUES_EVEN_R = 5'h12,
    CMD_QUES_ENAB_W = 5'h13,
    CMD_ERR_NEXT_R = 5'h14
  } cmd_e;

  // Flush-on-next-line tracker
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b01,
    LINE_ARMED = 2'b10
  } line_state_e;
endpackage

// *** rtl/status_reporting.sv ***
// Status reporting core: event status, status byte, service request, resets
`timescale 1ns/10ps
`default_nettype none
module status_reporting
  import status_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire status_pkg::cmd_e i_cmd_code,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_cmd_incompatible,
  output logic o_resp_valid,
  output logic [15:0] o_resp_data,
  output logic o_resp_no_error,
  input wire logic i_serial_poll,
  output logic o_poll_valid,
  output logic [7:0] o_poll_byte,
  input wire logic i_calibrating,
  input wire logic i_sweeping,
  input wire logic i_msg_available,
  input wire logic [7:0] i_esr_events,
  input wire logic i_opc_done,
  input wire logic i_error_valid,
  input wire logic [15:0] i_error_code,
  input wire logic i_power_on,
  input wire logic i_dev_clear,
  input wire logic i_line_start,
  output logic o_srq,
  output logic o_flush_out,
  output logic o_flush_in,
  output logic o_abort_cmd,
  output logic o_func_reset
);
  import status_pkg::*;

  logic [7:0] esr, ese, sre, ppe;
  logic psc;
  logic [15:0] oper_enable, ques_enable;
  logic [7:0] next_esr, next_ese, next_sre, next_ppe;
  logic next_psc;
  logic [15:0] next_oper_enable, next_ques_enable;
  logic resp_valid, resp_no_error, poll_valid, srq;
  logic [15:0] resp_data;
  logic [7:0] poll_byte;
  logic next_resp_valid, next_resp_no_error, next_poll_valid, next_srq;
  logic [15:0] next_resp_data;
  logic [7:0] next_poll_byte;
  logic flush_out, flush_in, func_reset;
  logic next_flush_out, next_flush_in, next_func_reset;
  line_state_e line_state, next_line_state;
  logic accepted, power_full, cls, err_pop, errq_empty;
  logic [15:0] oper_cond, oper_event, ques_cond, ques_event, err_head;
  logic [7:0] stb;
  logic srq_now;

  // Query commands produce a response word
  function automatic logic is_query(input cmd_e code);
    case (code)
      CMD_ESE_R, CMD_ESR_R, CMD_SRE_R, CMD_STB_R, CMD_PRE_R, CMD_PSC_R,
      CMD_OPER_COND_R, CMD_OPER_EVEN_R, CMD_QUES_COND_R, CMD_QUES_EVEN_R,
      CMD_ERR_NEXT_R: is_query = 1'b1;
      default: is_query = 1'b0;
    endcase
  endfunction

  // Command qualification and shared clear terms
  assign accepted = i_cmd_valid && !i_cmd_incompatible;
  assign cls = accepted && i_cmd_code == CMD_CLS;
  assign power_full = i_power_on && psc;
  assign err_pop = accepted && i_cmd_code == CMD_ERR_NEXT_R;

  // Operation and questionable register parts
  status_event_reg u_oper (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_cond({12'h000, i_sweeping, 2'b00, i_calibrating}),
    .i_used_mask(OPR_USED_MASK),
    .i_read_clear(accepted && i_cmd_code == CMD_OPER_EVEN_R),
    .i_clear(cls),
    .o_cond(oper_cond),
    .o_event(oper_event)
  );

  status_event_reg u_ques (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_cond(WORD_RESET),
    .i_used_mask(QUES_USED_MASK),
    .i_read_clear(accepted && i_cmd_code == CMD_QUES_EVEN_R),
    .i_clear(cls),
    .o_cond(ques_cond),
    .o_event(ques_event)
  );

  // Error queue, cleared on any power-on and on clear-status
  error_queue u_errq (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_push(i_error_valid),
    .i_push_code(i_error_code),
    .i_pop(err_pop),
    .i_clear(i_power_on || cls),
    .o_head(err_head),
    .o_empty(errq_empty)
  );

  // Status byte from live summaries; service request from enabled error queue, message and event summary bits only
  always_comb
  begin
    stb = BYTE_RESET;
    stb[STB_ERRQ_BIT] = !errq_empty;
    stb[STB_QUES_BIT] = |(ques_event & ques_enable);
    stb[STB_MAV_BIT] = i_msg_available;
    stb[STB_ESB_BIT] = |(esr & ese);
    stb[STB_OPER_BIT] = |(oper_event & oper_enable);
    srq_now = |(stb & sre & SRQ_SOURCE_MASK);
    stb[STB_MSS_BIT] = srq_now;
  end

  // Enable masks, event status and power-on flag
  always_comb
  begin
    next_esr = esr;
    next_ese = ese;
    next_sre = sre;
    next_ppe = ppe;
    next_psc = psc;
    next_oper_enable = oper_enable;
    next_ques_enable = ques_enable;
    if (power_full)
    begin
      next_esr = BYTE_RESET;
      next_ese = BYTE_RESET;
      next_sre = BYTE_RESET;
      next_ppe = BYTE_RESET;
    end
    if (cls || (accepted && i_cmd_code == CMD_ESR_R))
    begin
      next_esr = BYTE_RESET;
    end
    if (accepted)
    begin
      case (i_cmd_code)
        CMD_ESE_W: next_ese = i_cmd_data[7:0];
        CMD_SRE_W: next_sre = i_cmd_data[7:0] & SRE_WRITE_MASK;
        CMD_PRE_W: next_ppe = i_cmd_data[7:0];
        CMD_PSC_W: next_psc = i_cmd_data[0];
        CMD_OPER_ENAB_W: next_oper_enable = i_cmd_data & OPR_USED_MASK;
        CMD_QUES_ENAB_W: next_ques_enable = i_cmd_data & QUES_USED_MASK;
        default: next_psc = psc;
      endcase
    end
    // New events win over a clear in the same cycle
    next_esr = next_esr | i_esr_events;
    next_esr[ESR_OPC_BIT] = next_esr[ESR_OPC_BIT] | i_opc_done;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      esr <= BYTE_RESET;
      ese <= BYTE_RESET;
      sre <= BYTE_RESET;
      ppe <= BYTE_RESET;
      psc <= 1'b1;
      oper_enable <= WORD_RESET;
      ques_enable <= WORD_RESET;
    end
    else
    begin
      esr <= next_esr;
      ese <= next_ese;
      sre <= next_sre;
      ppe <= next_ppe;
      psc <= next_psc;
      oper_enable <= next_oper_enable;
      ques_enable <= next_ques_enable;
    end
  end

  // Query answers, serial poll and service request line
  always_comb
  begin
    next_resp_valid = accepted && is_query(i_cmd_code);
    next_resp_data = WORD_RESET;
    next_resp_no_error = 1'b0;
    case (i_cmd_code)
      CMD_ESE_R: next_resp_data = {8'h00, ese};
      CMD_ESR_R: next_resp_data = {8'h00, esr};
      CMD_SRE_R: next_resp_data = {8'h00, sre};
      CMD_STB_R: next_resp_data = {8'h00, stb};
      CMD_PRE_R: next_resp_data = {8'h00, ppe};
      CMD_PSC_R: next_resp_data = {15'h0000, psc};
      CMD_OPER_COND_R: next_resp_data = oper_cond;
      CMD_OPER_EVEN_R: next_resp_data = oper_event;
      CMD_QUES_COND_R: next_resp_data = ques_cond;
      CMD_QUES_EVEN_R: next_resp_data = ques_event;
      CMD_ERR_NEXT_R:
      begin
        next_resp_data = errq_empty ? NO_ERROR_CODE : err_head;
        next_resp_no_error = errq_empty;
      end
      default: next_resp_data = WORD_RESET;
    endcase
    if (!next_resp_valid)
    begin
      next_resp_data = WORD_RESET;
      next_resp_no_error = 1'b0;
    end
    next_poll_valid = i_serial_poll;
    next_poll_byte = i_serial_poll ? stb : poll_byte;
    next_srq = srq_now;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      resp_valid <= 1'b0;
      resp_data <= WORD_RESET;
      resp_no_error <= 1'b0;
      poll_valid <= 1'b0;
      poll_byte <= BYTE_RESET;
      srq <= 1'b0;
    end
    else
    begin
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
      resp_no_error <= next_resp_no_error;
      poll_valid <= next_poll_valid;
      poll_byte <= next_poll_byte;
      srq <= next_srq;
    end
  end

  // Buffer flushes, pending line flush and settings reset pulses
  always_comb
  begin
    next_line_state = line_state;
    next_flush_in = i_dev_clear || i_power_on;
    next_flush_out = i_dev_clear || i_power_on;
    next_func_reset = accepted &&
      (i_cmd_code == CMD_RST || i_cmd_code == CMD_SYS_PRESET);
    case (line_state)
      LINE_IDLE: next_line_state = LINE_IDLE;
      LINE_ARMED:
      begin
        if (i_line_start)
        begin
          next_flush_out = 1'b1;
          next_line_state = LINE_IDLE;
        end
      end
      default: next_line_state = LINE_IDLE;
    endcase
    if (accepted && (i_cmd_code == CMD_RST || i_cmd_code == CMD_SYS_PRESET ||
        i_cmd_code == CMD_STAT_PRESET || i_cmd_code == CMD_CLS))
    begin
      next_line_state = LINE_ARMED;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      line_state <= LINE_IDLE;
      flush_out <= 1'b0;
      flush_in <= 1'b0;
      func_reset <= 1'b0;
    end
    else
    begin
      line_state <= next_line_state;
      flush_out <= next_flush_out;
      flush_in <= next_flush_in;
      func_reset <= next_func_reset;
    end
  end

  assign o_resp_valid = resp_valid;
  assign o_resp_data = resp_data;
  assign o_resp_no_error = resp_no_error;
  assign o_poll_valid = poll_valid;
  assign o_poll_byte = poll_byte;
  assign o_srq = srq;
  assign o_flush_out = flush_out;
  assign o_flush_in = flush_in;
  assign o_abort_cmd = flush_in;
  assign o_func_reset = func_reset;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  ques_unused_a: assert property (ques_cond == WORD_RESET && ques_event == WORD_RESET)
    else $error("questionable register shows a set bit");
  oper_bits_a: assert property (##1 oper_cond == {12'h000, $past(i_sweeping), 2'b00,
    $past(i_calibrating)}) else $error("operation condition does not track activity");
  srq_raise_a: assert property (sre[STB_ESB_BIT] && (esr & ese) != BYTE_RESET
    |=> o_srq) else $error("enabled event summary gave no service request");
  srq_quiet_a: assert property ((stb & sre & SRQ_SOURCE_MASK) == BYTE_RESET
    |=> !o_srq) else $error("service request without enabled source");
  poll_byte_a: assert property (i_serial_poll |=> o_poll_valid &&
    o_poll_byte == $past(stb)) else $error("serial poll did not return the status byte");
  esr_read_a: assert property (accepted && i_cmd_code == CMD_ESR_R && !i_opc_done
    && i_esr_events == 8'h00 |=> esr == BYTE_RESET && o_resp_data == {8'h00, $past(esr)})
    else $error("event status read did not return and clear");
  err_empty_a: assert property (err_pop && errq_empty |=> o_resp_no_error &&
    o_resp_data == NO_ERROR_CODE) else $error("empty error queue did not answer zero");
  psc_clear_a: assert property (power_full && !i_cmd_valid |=> sre == BYTE_RESET &&
    ese == BYTE_RESET && ppe == BYTE_RESET) else $error("power-on clear left enable masks");
  dev_clear_a: assert property (i_dev_clear && !i_cmd_valid && !i_power_on |=>
    o_flush_in && o_abort_cmd && o_flush_out && sre == $past(sre) && ese == $past(ese))
    else $error("device clear misbehaved");
  line_flush_a: assert property (line_state == LINE_ARMED && i_line_start
    |=> o_flush_out) else $error("armed line start did not flush output");
  func_reset_a: assert property (o_func_reset |-> $past(accepted) &&
    ($past(i_cmd_code) == CMD_RST || $past(i_cmd_code) == CMD_SYS_PRESET))
    else $error("settings reset from wrong source");
  discard_a: assert property (i_cmd_valid && i_cmd_incompatible |=>
    !o_resp_valid && !o_func_reset && ese == $past(ese) && sre == $past(sre))
    else $error("incompatible command changed state");

  opc_srq_c: cover property (i_opc_done && ese[ESR_OPC_BIT] && sre[STB_ESB_BIT] ##2 o_srq);
  err_read_c: cover property (err_pop && !errq_empty ##1 o_resp_valid);
  line_flush_c: cover property (cls ##[1:20] (i_line_start && line_state == LINE_ARMED));
endmodule
`default_nettype wire

// *** tb/remote_ctrl_model.sv ***
// Remote controller model issuing commands and serial polls
`timescale 1ns/10ps
`default_nettype none
module remote_ctrl_model
  import status_pkg::*;
(
  input wire logic i_clock,
  output logic o_cmd_valid,
  output status_pkg::cmd_e o_cmd_code,
  output logic [15:0] o_cmd_data,
  output logic o_cmd_incompatible,
  output logic o_serial_poll,
  input wire logic i_resp_valid,
  input wire logic [15:0] i_resp_data,
  input wire logic i_resp_no_error,
  input wire logic i_poll_valid,
  input wire logic [7:0] i_poll_byte
);
  logic got, empty, pgot;
  logic [15:0] rdata;
  logic [7:0] pbyte;
  // Bus idle from time zero
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = CMD_CLS;
    o_cmd_data = 16'h0000;
    o_cmd_incompatible = 1'b0;
    o_serial_poll = 1'b0;
  end
  // One setting or query per message, answer taken a cycle later
  task automatic send(input cmd_e code, input logic [15:0] data, input logic bad);
    @(posedge i_clock);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_data = data;
    o_cmd_incompatible = bad;
    @(posedge i_clock);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_incompatible = 1'b0;
    o_cmd_data = ~data; // Released data never shows the old value
    got = i_resp_valid;
    rdata = i_resp_data;
    empty = i_resp_no_error;
  endtask
  // Serial poll through interface messages
  task automatic poll;
    @(posedge i_clock);
    #1;
    o_serial_poll = 1'b1;
    @(posedge i_clock);
    #1;
    o_serial_poll = 1'b0;
    pgot = i_poll_valid;
    pbyte = i_poll_byte;
  endtask
endmodule
`default_nettype wire

// *** tb/status_reporting_tb.sv ***
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
module status_reporting_tb;
  import status_pkg::*;
  localparam logic [4:0] P_OPC = 5'h10;
  localparam logic [4:0] P_ERR = 5'h08;
  localparam logic [4:0] P_PON = 5'h04;
  localparam logic [4:0] P_DCL = 5'h02;
  localparam logic [4:0] P_LINE = 5'h01;
  localparam cmd_e RSTS [4] = '{CMD_RST, CMD_SYS_PRESET, CMD_STAT_PRESET, CMD_CLS};
  localparam logic [3:0] FUNC = 4'b0011;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cal = 1'b0;
  logic sweep = 1'b0;
  logic mav = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic [7:0] esr_ev = 8'h00;
  logic [4:0] pul = 5'h00;
  logic cmd_valid, cmd_bad, poll, resp_valid, no_err, poll_valid;
  logic srq, flush_out, flush_in, abort, func_reset;
  cmd_e cmd_code;
  logic [15:0] cmd_data, resp_data;
  logic [7:0] poll_byte;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      results();
    end
  end
  status_reporting dut_u (
    .i_clock(clock), .i_reset_n(reset_n), .i_cmd_valid(cmd_valid),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .i_cmd_incompatible(cmd_bad),
    .o_resp_valid(resp_valid), .o_resp_data(resp_data), .o_resp_no_error(no_err),
    .i_serial_poll(poll), .o_poll_valid(poll_valid), .o_poll_byte(poll_byte),
    .i_calibrating(cal), .i_sweeping(sweep), .i_msg_available(mav),
    .i_esr_events(esr_ev), .i_opc_done(pul[4]), .i_error_valid(pul[3]),
    .i_error_code(err_code), .i_power_on(pul[2]), .i_dev_clear(pul[1]),
    .i_line_start(pul[0]), .o_srq(srq), .o_flush_out(flush_out),
    .o_flush_in(flush_in), .o_abort_cmd(abort), .o_func_reset(func_reset)
  );
  remote_ctrl_model ctrl_u (
    .i_clock(clock), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
    .o_cmd_data(cmd_data), .o_cmd_incompatible(cmd_bad), .o_serial_poll(poll),
    .i_resp_valid(resp_valid), .i_resp_data(resp_data), .i_resp_no_error(no_err),
    .i_poll_valid(poll_valid), .i_poll_byte(poll_byte)
  );
  task automatic results;
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Query with answer expected
  task automatic ask(input cmd_e c, input logic [15:0] exp);
    ctrl_u.send(c, 16'h0000, 1'b0);
    check("answer strobe", 16'h0001, 16'(ctrl_u.got));
    check(c.name(), exp, ctrl_u.rdata);
  endtask
  // Write or refused command, no answer
  task automatic wr(input cmd_e c, input logic [15:0] d, input logic bad);
    ctrl_u.send(c, d, bad);
    check("no answer", 16'h0000, 16'(ctrl_u.got));
  endtask
  task automatic outs(input logic [3:0] e);
    check("flush pulses", 16'(e), 16'({flush_out, flush_in, abort, func_reset}));
  endtask
  task automatic pulse(input logic [4:0] p);
    @(posedge clock);
    #1;
    pul = p;
    @(posedge clock);
    #1;
    pul = 5'h00;
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic t_reset_vals;
    ask(CMD_PSC_R, 16'h0001);
    ask(CMD_ESE_R, 16'h0000);
    ask(CMD_SRE_R, 16'h0000);
    ask(CMD_ESR_R, 16'h0000);
    ask(CMD_ERR_NEXT_R, NO_ERROR_CODE);
    check("empty flag", 16'h0001, 16'(ctrl_u.empty));
  endtask
  task automatic t_oper;
    cal = 1'b1;
    sweep = 1'b1;
    ask(CMD_OPER_COND_R, 16'h0009);
    cal = 1'b0;
    ask(CMD_OPER_COND_R, 16'h0008);
    sweep = 1'b0;
    settle();
    ask(CMD_OPER_COND_R, 16'h0000);
    ask(CMD_OPER_EVEN_R, 16'h0009);
    ask(CMD_OPER_EVEN_R, 16'h0000);
    wr(CMD_QUES_ENAB_W, 16'hffff, 1'b0);
    ask(CMD_QUES_COND_R, 16'h0000);
    ask(CMD_QUES_EVEN_R, 16'h0000);
  endtask
  task automatic t_opc_srq;
    wr(CMD_ESE_W, 16'h0001, 1'b0);
    wr(CMD_SRE_W, 16'h0020, 1'b0);
    pulse(P_OPC);
    settle();
    check("srq", 16'h0001, 16'(srq));
    ctrl_u.poll();
    check("poll strobe", 16'h0001, 16'(ctrl_u.pgot));
    check("poll byte", 16'h0060, 16'(ctrl_u.pbyte));
    ask(CMD_STB_R, 16'h0060);
    ask(CMD_ESR_R, 16'h0001);
    ask(CMD_ESR_R, 16'h0000);
    esr_ev = 8'h20;
    settle();
    esr_ev = 8'h00;
    ask(CMD_STB_R, 16'h0000);
    ask(CMD_ESR_R, 16'h0020);
    settle();
    check("srq", 16'h0000, 16'(srq));
  endtask
  task automatic t_errq;
    wr(CMD_SRE_W, 16'h00ff, 1'b0);
    ask(CMD_SRE_R, 16'h00bf);
    wr(CMD_OPER_ENAB_W, 16'hffff, 1'b0);
    cal = 1'b1;
    settle();
    cal = 1'b0;
    check("srq", 16'h0000, 16'(srq));
    mav = 1'b1;
    settle();
    check("srq", 16'h0001, 16'(srq));
    mav = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      err_code = 16'(i + 1);
      pulse(P_ERR);
    end
    settle();
    check("srq", 16'h0001, 16'(srq));
    for (int i = 0; i < ERRQ_DEPTH; i++)
      ask(CMD_ERR_NEXT_R, 16'(i + 1));
    ask(CMD_ERR_NEXT_R, NO_ERROR_CODE);
    settle();
    check("srq", 16'h0000, 16'(srq));
  endtask
  task automatic t_resets;
    wr(CMD_ESE_W, 16'h0021, 1'b0);
    wr(CMD_PRE_W, 16'h005a, 1'b0);
    ask(CMD_PRE_R, 16'h005a);
    pulse(P_PON);
    outs(4'he);
    ask(CMD_ESE_R, 16'h0000);
    ask(CMD_SRE_R, 16'h0000);
    ask(CMD_PRE_R, 16'h0000);
    wr(CMD_ESE_W, 16'h0021, 1'b0);
    wr(CMD_PSC_W, 16'h0000, 1'b0);
    pulse(P_ERR);
    pulse(P_PON);
    outs(4'he);
    ask(CMD_ESE_R, 16'h0021);
    ask(CMD_ERR_NEXT_R, NO_ERROR_CODE);
    pulse(P_DCL);
    outs(4'he);
    ask(CMD_ESE_R, 16'h0021);
    pulse(P_LINE);
    outs(4'h0);
    for (int i = 0; i < 4; i++)
    begin
      pulse(P_ERR | P_OPC);
      wr(RSTS[i], 16'h0000, 1'b0);
      outs({3'b000, FUNC[i]});
      pulse(P_LINE);
      outs(4'h8);
    end
    ask(CMD_ERR_NEXT_R, NO_ERROR_CODE);
    ask(CMD_ESR_R, 16'h0000);
    ask(CMD_OPER_EVEN_R, 16'h0000);
  endtask
  task automatic t_bad;
    wr(CMD_ESE_W, 16'h00ff, 1'b1);
    wr(CMD_ESE_R, 16'h0000, 1'b1);
    wr(CMD_RST, 16'h0000, 1'b1);
    outs(4'h0);
    ask(CMD_ESE_R, 16'h0021);
  endtask
  // Reset, then scenarios in turn
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_reset_vals();
    t_oper();
    t_opc_srq();
    t_errq();
    t_resets();
    t_bad();
    results();
  end
endmodule
`default_nettype wire
